// *** hdl/flash_poll_pkg.sv ***
// package: constants, states and carriers for the flash status poller
`default_nettype none
package flash_poll_pkg;
  // status bit positions on the data bus
  localparam int unsigned POLL_BIT    = 7;
  localparam int unsigned TOGGLE1_BIT = 6;
  localparam int unsigned TIMEOUT_BIT = 5;
  localparam int unsigned WINDOW_BIT  = 3;
  localparam int unsigned TOGGLE2_BIT = 2;
  // bus timing in clk_sys cycles
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned READ_TIME_NS  = 100;
  localparam int unsigned READ_CYCLES   = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_TIME_NS = 50;
  localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // spacing limit for added sector erase commands
  localparam int unsigned ADD_ERASE_GAP_US = 50;
  localparam int unsigned ADD_ERASE_GAP_CYCLES = ADD_ERASE_GAP_US * 1000 / CLK_PERIOD_NS;
  // reset command data
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  // controller states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_READ_A = 8'h02,
    ST_READ_B = 8'h04,
    ST_DECIDE = 8'h08,
    ST_RECHK  = 8'h10,
    ST_RESET  = 8'h20,
    ST_WIN    = 8'h40,
    ST_DONE   = 8'h80
  } poll_state_t;
  // external bus pins toward the flash
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
  } flash_pins_t;
  // result reported to the user
  typedef struct packed {
    logic        pass;
    logic        fail;
    logic        window_closed;
    logic [15:0] data;
  } poll_result_t;
endpackage
`default_nettype wire

// *** hdl/flash_write_status_poll.sv ***
// host-side poller for flash program and erase status
`default_nettype none
module flash_write_status_poll #(
  parameter int unsigned ADDR_W = 22
) (
  input  wire logic                         clk_sys,        // system clock
  input  wire logic                         rst,            // sync reset, active high
  input  wire logic                         start_poll,     // pulse: begin status check
  input  wire logic                         abandon,        // pulse: leave polling
  input  wire logic                         check_window,   // pulse: sample window bit
  input  wire logic [ADDR_W-1:0]            poll_addr,      // program or erasing sector address
  input  wire logic [15:0]                  dq_in,          // data pins from flash
  input  wire logic                         ready_busy_in,  // ready/busy pin from flash
  output var  flash_poll_pkg::flash_pins_t  pins,           // bus pins to flash
  output var  flash_poll_pkg::poll_result_t result,         // outcome of last check
  output logic                              done,           // pulse: result valid
  output logic                              busy,           // controller busy
  output logic                              device_busy     // synchronised ready/busy low
);
  // synchronisers for the pins
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic        rb_s1;
  logic        rb_s2;
  // state and bookkeeping
  flash_poll_pkg::poll_state_t state;
  logic [7:0]        cnt;          // bus cycle timer
  logic              first_tog;    // toggle bit from first read
  logic [15:0]       last_data;    // most recent read
  logic              rechecked;    // timeout recheck already done
  // the poll address goes into the pin register at start and stays there
  // for the whole check, so no separate copy is kept

  // two-stage synchronisers on data and ready/busy
  // status is sampled deep inside a read, so the lag costs nothing
  always_ff @(posedge clk_sys)
  begin
    dq_s1 <= dq_in;
    dq_s2 <= dq_s1;
    rb_s1 <= ready_busy_in;
    rb_s2 <= rb_s1;
  end

  // device busy view, ready/busy low means busy
  // only the settled second-stage copy feeds this flag
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      device_busy <= 1'b0;
    else
      device_busy <= ~rb_s2;
  end

  // status sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state       <= flash_poll_pkg::ST_IDLE;
      cnt         <= 8'h00;
      first_tog   <= 1'b0;
      last_data   <= 16'h0000;
      rechecked   <= 1'b0;
      done        <= 1'b0;
      busy        <= 1'b0;
      result      <= '0;
      pins        <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
    end
    else
    begin
      // done is a one-cycle pulse unless a state raises it
      done <= 1'b0;
      // abandon is refused while the reset write is on the bus, so a
      // half-written command never reaches the flash
      if (abandon && state != flash_poll_pkg::ST_IDLE && state != flash_poll_pkg::ST_RESET)
      begin
        // leaving drops history; next start begins with a fresh double read
        state     <= flash_poll_pkg::ST_IDLE;
        busy      <= 1'b0;
        rechecked <= 1'b0;
        pins.ce_n <= 1'b1;
        pins.oe_n <= 1'b1;
      end
      else
      begin
        case (state)
          // wait for a request
          flash_poll_pkg::ST_IDLE:
          begin
            if (start_poll || check_window)
            begin
              // window read always on offer; no reliance on add spacing
              pins.addr   <= 22'(poll_addr);
              pins.ce_n   <= 1'b0;
              pins.oe_n   <= 1'b0;
              cnt         <= 8'h00;
              rechecked   <= 1'b0;
              busy        <= 1'b1;
              state       <= check_window ? flash_poll_pkg::ST_WIN
                                          : flash_poll_pkg::ST_READ_A;
            end
          end
          // first read of the pair
          flash_poll_pkg::ST_READ_A:
          begin
            cnt <= cnt + 8'h01;
            if (cnt == 8'(flash_poll_pkg::READ_CYCLES + 2))
            begin
              first_tog  <= dq_s2[flash_poll_pkg::TOGGLE1_BIT];
              pins.oe_n  <= 1'b1;                                           // end read cycle
              cnt        <= 8'h00;
              state      <= flash_poll_pkg::ST_READ_B;
            end
          end
          // second read of the pair, back to back
          flash_poll_pkg::ST_READ_B:
          begin
            cnt       <= cnt + 8'h01;
            // a high gap lets the flash see two separate read cycles
            pins.oe_n <= (cnt == 8'h00);                                    // two idle cycles
            if (cnt == 8'(flash_poll_pkg::READ_CYCLES + 3))
            begin
              last_data <= dq_s2;
              pins.oe_n <= 1'b1;
              cnt       <= 8'h00;
              state     <= flash_poll_pkg::ST_DECIDE;
            end
          end
          // compare toggle bits and act on the timeout bit
          flash_poll_pkg::ST_DECIDE:
          begin
            if (last_data[flash_poll_pkg::TOGGLE1_BIT] == first_tog)
            begin
              // steady: operation finished, next read gives array data
              result.pass <= 1'b1;
              result.fail <= 1'b0;
              state       <= flash_poll_pkg::ST_DONE;
            end
            else if (last_data[flash_poll_pkg::TIMEOUT_BIT] && rechecked)
            begin
              // still toggling after recheck: failure, issue reset
              result.pass <= 1'b0;
              result.fail <= 1'b1;
              pins.we_n   <= 1'b0;
              pins.dq_out <= flash_poll_pkg::RESET_CMD;
              pins.dq_oe  <= 1'b1;
              cnt         <= 8'h00;
              state       <= flash_poll_pkg::ST_RESET;
            end
            else
            begin
              // timeout seen: one more pair; otherwise keep polling
              rechecked <= last_data[flash_poll_pkg::TIMEOUT_BIT];
              pins.oe_n <= 1'b0;
              state     <= flash_poll_pkg::ST_READ_A;
            end
          end
          // write cycle carrying the reset command
          flash_poll_pkg::ST_RESET:
          begin
            cnt <= cnt + 8'h01;
            if (cnt == 8'(flash_poll_pkg::WRITE_CYCLES))
            begin
              pins.we_n  <= 1'b1;
              pins.ce_n  <= 1'b1;
              pins.dq_oe <= 1'b0;
              state      <= flash_poll_pkg::ST_DONE;
            end
          end
          // single read of the erase window bit
          flash_poll_pkg::ST_WIN:
          begin
            cnt <= cnt + 8'h01;
            if (cnt == 8'(flash_poll_pkg::READ_CYCLES + 2))
            begin
              // high means erasure started; further adds may be refused
              result.window_closed <= dq_s2[flash_poll_pkg::WINDOW_BIT];
              last_data            <= dq_s2;
              pins.oe_n            <= 1'b1;
              state                <= flash_poll_pkg::ST_DONE;
            end
          end
          // report and release the bus
          flash_poll_pkg::ST_DONE:
          begin
            // last word read: array data after a pass
            result.data <= last_data;
            pins.ce_n   <= 1'b1;
            pins.oe_n   <= 1'b1;
            done        <= 1'b1;
            busy        <= 1'b0;
            state       <= flash_poll_pkg::ST_IDLE;
          end
          // an illegal code falls back to idle
          default:
            state <= flash_poll_pkg::ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** test/flash_dev_model.sv ***
// device model: flash status bits during an embedded operation
`default_nettype none
module flash_dev_model (
  input  wire logic                        clk_sys,
  input  wire flash_poll_pkg::flash_pins_t pins,
  input  wire logic                        load,      // arm a new operation
  input  wire logic [7:0]                  run_reads, // reads until finished
  // fail also covers a one programmed over a zero: halt, then timeout bit
  input  wire logic                        fail,      // pulse limit exceeded
  // while open, added sector erases are taken; once shut only suspend
  input  wire logic                        win_open,  // accept window open
  output logic [15:0]                      dq,
  output logic                             rdy
);
  logic [7:0]  left = 8'h00;     // reads left while running
  logic        tog = 1'b0;       // toggle state
  logic        rd_q = 1'b0;      // read seen last cycle
  logic [15:0] last = 16'h0000;  // last word driven
  logic        rd;
  assign rd = !pins.ce_n && !pins.oe_n;
  assign rdy = (left == 8'h00); // low while running
  // poll bit shows the complement of array bit 7 (a one) while running
  // released bus shows inverse; status while running, array after
  assign dq = !rd ? ~last : (left == 8'h00) ? 16'h00A5
            : {8'h00, 1'b0, tog, fail, 1'b0, !win_open, tog, 2'b00};
  // each read end while running inverts toggles reset write stops run
  always_ff @(posedge clk_sys)
  begin
    rd_q <= rd;
    if (rd) last <= dq;
    if (load) left <= run_reads;
    else if (!pins.we_n && pins.dq_out == flash_poll_pkg::RESET_CMD) left <= 8'h00;
    else if (rd_q && !rd && left != 8'h00)
    begin
      left <= left - 8'h01;
      tog <= !tog;
    end
  end
endmodule
`default_nettype wire

// *** test/flash_poll_monitor.sv ***
// checker: port-level properties of the status poller
`default_nettype none
module flash_poll_monitor (
  input wire logic                         clk_sys,
  input wire logic                         rst,
  input wire logic                         start_poll,
  input wire logic                         check_window,
  input wire logic                         ready_busy_in,
  input wire flash_poll_pkg::flash_pins_t  pins,
  input wire flash_poll_pkg::poll_result_t result,
  input wire logic                         done,
  input wire logic                         busy,
  input wire logic                         device_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_reset_idle: assert property (disable iff (1'b0)
    rst |=> pins.ce_n && pins.we_n && !pins.dq_oe && !busy) else $error("bus busy after reset");
  chk_start_taken: assert property (
    (start_poll || check_window) && !busy |=> busy) else $error("request not taken");
  chk_first_read: assert property (
    $rose(busy) |-> !pins.ce_n && !pins.oe_n && pins.we_n) else $error("no read at start");
  chk_one_done: assert property (done |=> !done) else $error("done longer than one cycle");
  chk_done_idle: assert property (
    done |-> !busy && !(result.pass && result.fail)) else $error("bad done state");
  chk_reset_cmd: assert property (
    !pins.we_n |-> pins.dq_oe && pins.oe_n && pins.dq_out == flash_poll_pkg::RESET_CMD)
    else $error("bad write cycle");
  chk_addr_hold: assert property (
    busy && $past(busy) |-> $stable(pins.addr)) else $error("address moved");
  chk_busy_sync: assert property (
    !$past(rst, 3) |-> device_busy == !$past(ready_busy_in, 3)) else $error("busy lag wrong");
endmodule
bind flash_write_status_poll flash_poll_monitor mon_u (.clk_sys(clk_sys), .rst(rst),
  .start_poll(start_poll), .check_window(check_window), .ready_busy_in(ready_busy_in),
  .pins(pins), .result(result), .done(done), .busy(busy), .device_busy(device_busy));
`default_nettype wire

// *** test/flash_write_status_poll_tb.sv ***
// testbench: status poller against the flash device model
`default_nettype none
module flash_write_status_poll_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, start_poll = 1'b0, abandon = 1'b0, check_window = 1'b0;
  logic load = 1'b0, fail = 1'b0, win_open = 1'b0, done, busy, device_busy, ready_busy_in;
  logic [7:0]  run_reads = 8'h00;
  logic [21:0] poll_addr = 22'h012345;
  logic [15:0] dq_in;
  flash_poll_pkg::flash_pins_t  pins;
  flash_poll_pkg::poll_result_t result;
  int error_cnt = 0, tests_run = 0;
  flash_write_status_poll dut_u (.clk_sys(clk_sys), .rst(rst), .start_poll(start_poll),
    .abandon(abandon), .check_window(check_window), .poll_addr(poll_addr), .dq_in(dq_in),
    .ready_busy_in(ready_busy_in), .pins(pins), .result(result), .done(done), .busy(busy),
    .device_busy(device_busy));
  flash_dev_model dev_u (.clk_sys(clk_sys), .pins(pins), .load(load), .run_reads(run_reads),
    .fail(fail), .win_open(win_open), .dq(dq_in), .rdy(ready_busy_in));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // arm the device model for a new operation
  task automatic arm(input logic [7:0] n, input logic f, input logic w);
    @(posedge clk_sys);
    load <= 1'b1;
    run_reads <= n;
    fail <= f;
    win_open <= w;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask
  // one request, bounded wait for done
  task automatic req(input logic win);
    int i;
    @(posedge clk_sys);
    start_poll <= !win;
    check_window <= win;
    @(posedge clk_sys);
    start_poll <= 1'b0;
    check_window <= 1'b0;
    for (i = 0; i < 4000 && done !== 1'b1; i++) @(posedge clk_sys) #1;
    chk(16'(done), 16'h0001);
  endtask
  // full status check, expect {pass, fail}
  task automatic poll(input logic [7:0] n, input logic f, input logic [15:0] exp);
    arm(n, f, 1'b0);
    req(1'b0);
    chk(16'({result.pass, result.fail}), exp);
  endtask
  // operation ends after a few reads; last word is array data
  task automatic t_pass;
    poll(8'h03, 1'b0, 16'h0002);
    chk(result.data, 16'h00A5);
    $display("pass test done");
  endtask
  // timeout seen just as toggling stops: recheck passes
  task automatic t_recover;
    poll(8'h02, 1'b1, 16'h0002);
    $display("recover test done");
  endtask
  // still toggling with timeout: fail, reset write ends the operation
  task automatic t_fail;
    poll(8'hFF, 1'b1, 16'h0001);
    repeat (5) @(posedge clk_sys) #1;
    chk(16'(device_busy), 16'h0000);
    $display("fail test done");
  endtask
  task automatic t_window;
    arm(8'hFF, 1'b0, 1'b1);
    req(1'b1);
    chk(16'(result.window_closed), 16'h0000);
    arm(8'hFF, 1'b0, 1'b0);
    req(1'b1);
    chk(16'(result.window_closed), 16'h0001);
    chk(16'(device_busy), 16'h0001);
    $display("window test done");
  endtask
  task automatic t_abandon;
    arm(8'hFF, 1'b0, 1'b0);
    start_poll <= 1'b1;
    @(posedge clk_sys);
    start_poll <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk(pins.addr[15:0], 16'h2345);
    chk(16'(pins.addr[21:16]), 16'h0001);
    abandon <= 1'b1;
    @(posedge clk_sys);
    abandon <= 1'b0;
    repeat (3) @(posedge clk_sys) #1;
    chk(16'(busy), 16'h0000);
    poll(8'h02, 1'b0, 16'h0002);
    $display("abandon test done");
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // a few thousand cycles per request; far beyond the run
  initial
  begin
    #400us;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_pass;
    t_recover;
    t_fail;
    t_window;
    t_abandon;
    stop_test;
  end
endmodule
`default_nettype wire
